// [verilog/fpio_pkg.sv]
// Constants, register offsets and reset values of the four-port parallel I/O.
// Assumes a CPU timing generator that marks the S1 and S2 states of a cycle.
//
// Functional notes
// [RQ1] Output values stay in latches; inputs are seen only when sampled.
// [RQ2] Port reads sample pin levels in state S1 of the read cycle.
// [RQ3] Port writes change the outputs in state S2 of the write cycle.
// [RQ4] Reset sets port 0 latch to all ones, drive type to zero.
// [RQ5] Port 0 drive type bit picks open-drain or push-pull per pin.
// [RQ6] Port 0 latch reads return latch; pin-level register returns pins.
// [RQ7] Port 1 direction zero means input; direction and latch reset zero.
// [RQ8] Software sets port 1 latch to one before making function outputs.
// [RQ9] Port 1 bit 1 edges still flag its interrupt while driven out.
// [RQ10] Port 1 bit 0 is I/O or interrupt by pin select; input after reset.
// [RQ11] Port 2 latch resets to ones; ones needed for input use.
// [RQ12] Port 2 pin-level register; bits 7 to 3 undefined on reads.
// [RQ13] Port 2 bit 0 floats in stop mode regardless of drive enable.
// [RQ14] Port 2 bit 0 falling edge flags interrupt even when driven.
// [RQ15] Port 3 direction and latch reset zero; all pins digital inputs.
// [RQ16] Analog disable zero turns selected port 3 pins to analog inputs.
// [RQ17] Port 3 direction one drives the matching latch bit out.
// [RQ18] Analog pins read latch value; other port 3 pins read pin level. Output-mode pins read the latch instead.
// [RQ19] Writes never drive latch data onto analog-selected port 3 pins.
// [RQ20] Input-mode pins read pin level, so bit writes may overwrite latches.
// [RQ21] Software avoids read-modify-write on write-only regs and latches.
// [RQ22] Software never touches reserved or inaccessible addresses.
// [RQ23] Pin select one gives interrupt use; the pin must stay input.

package fpio_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int P0_W = 8;
  localparam int P1_W = 5;
  localparam int P2_W = 3;
  localparam int P3_W = 8;
  localparam int CHSEL_W = 3;
  localparam int PIN_W = P0_W + P1_W + P2_W + P3_W;

  // Bit positions of the pin groups inside the sampled pin vector
  localparam int P0_LSB = 0;
  localparam int P1_LSB = P0_LSB + P0_W;
  localparam int P2_LSB = P1_LSB + P1_W;
  localparam int P3_LSB = P2_LSB + P2_W;

  // Pins with shared interrupt edge detection
  localparam int P1_IRQ0_BIT = 0;
  localparam int P1_IRQ1_BIT = 1;
  localparam int P2_IRQ_BIT = 0;

  // Synchroniser depth; edge history is trusted one edge after it fills
  localparam int SYNC_STAGES = 2;
  localparam int WARM_CYC = SYNC_STAGES + 1;
  localparam int WARM_W = 2;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  typedef logic [ADDR_W-1:0] fpio_addr_t;
  localparam fpio_addr_t OFS_P0_LATCH = 6'h00;
  localparam fpio_addr_t OFS_P1_LATCH = 6'h01;
  localparam fpio_addr_t OFS_P2_LATCH = 6'h02;
  localparam fpio_addr_t OFS_P3_LATCH = 6'h03;
  localparam fpio_addr_t OFS_P1_DIR = 6'h09;
  localparam fpio_addr_t OFS_P3_DIR = 6'h0a;
  localparam fpio_addr_t OFS_P0_DRIVE = 6'h0b;
  localparam fpio_addr_t OFS_P0_PINS = 6'h0c;
  localparam fpio_addr_t OFS_P2_PINS = 6'h0d;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [P0_W-1:0] RST_P0_LATCH = 8'hff;
  localparam logic [P0_W-1:0] RST_P0_DRIVE = 8'h00;
  localparam logic [P1_W-1:0] RST_P1_LATCH = 5'h00;
  localparam logic [P1_W-1:0] RST_P1_DIR = 5'h00;
  localparam logic [P2_W-1:0] RST_P2_LATCH = 3'h7;
  localparam logic [P3_W-1:0] RST_P3_LATCH = 8'h00;
  localparam logic [P3_W-1:0] RST_P3_DIR = 8'h00;
  localparam logic [DATA_W-1:0] RD_IDLE = 8'h00;

endpackage : fpio_pkg

// [verilog/fpio_sync_if.sv]
// Carrier between the port core and its pin synchroniser.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps

interface fpio_sync_if #(
  parameter int W = 24
);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  logic [W-1:0] level_prev;

  // Synchroniser end
  modport sync (
    input raw,
    output level,
    output level_prev
  );

  // Port core end
  modport core (
    output raw,
    input level,
    input level_prev
  );
endinterface : fpio_sync_if

// [verilog/fpio_pin_sync.sv]
// Pin synchroniser with a one-cycle history for edge detection.
// Assumes raw pin levels are asynchronous to clk_sys.
`timescale 1ns/10ps

module fpio_pin_sync #(
  parameter int W = 24,
  parameter int STAGES = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  fpio_sync_if.sync s
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (STAGES < 2) begin : g_bad_stages
    $error("fpio_pin_sync needs at least two stages");
  end

  logic [W-1:0] chain_r [STAGES];
  logic [W-1:0] prev_r;

  // Metastability chain; only the next stage reads stage 0
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < STAGES; i++) begin
        chain_r[i] <= '0;
      end
    end else begin
      chain_r[0] <= s.raw;
      for (int i = 1; i < STAGES; i++) begin
        chain_r[i] <= chain_r[i-1];
      end
    end
  end

  // History for edge detectors
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= '0;
    end else begin
      prev_r <= chain_r[STAGES-1];
    end
  end

  assign s.level = chain_r[STAGES-1];
  assign s.level_prev = prev_r;

endmodule : fpio_pin_sync

// [verilog/fpio_ports.sv]
// Four parallel ports: latches, direction and drive control, pin reads.
// Assumes the CPU raises st_s1 and st_s2 for one clk_sys each per
// instruction cycle and holds address and strobes across the cycle.
`timescale 1ns/10ps

module fpio_ports (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic st_s1,
  input wire logic st_s2,
  input wire logic [fpio_pkg::ADDR_W-1:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic [fpio_pkg::DATA_W-1:0] sfr_wdata,
  output logic [fpio_pkg::DATA_W-1:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic ext_irq_zero_pin_select,
  input wire logic analog_input_disable,
  input wire logic [fpio_pkg::CHSEL_W-1:0] analog_channel_select,
  input wire logic stop_mode,
  input wire logic [fpio_pkg::P0_W-1:0] p0_in,
  output logic [fpio_pkg::P0_W-1:0] p0_out,
  output logic [fpio_pkg::P0_W-1:0] p0_oe,
  input wire logic [fpio_pkg::P1_W-1:0] p1_in,
  output logic [fpio_pkg::P1_W-1:0] p1_out,
  output logic [fpio_pkg::P1_W-1:0] p1_oe,
  input wire logic [fpio_pkg::P2_W-1:0] p2_in,
  output logic [fpio_pkg::P2_W-1:0] p2_out,
  output logic [fpio_pkg::P2_W-1:0] p2_oe,
  input wire logic [fpio_pkg::P3_W-1:0] p3_in,
  output logic [fpio_pkg::P3_W-1:0] p3_out,
  output logic [fpio_pkg::P3_W-1:0] p3_oe,
  output logic [fpio_pkg::P3_W-1:0] p3_analog_sel,
  output logic irq0_fall,
  output logic irq1_edge,
  output logic irq2_fall
);
  import fpio_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Channel index must cover port 3 exactly; counter must reach warm-up
  if ((1 << CHSEL_W) != P3_W || WARM_CYC >= (1 << WARM_W)) begin : g_bad_cfg
    $error("fpio_ports: channel select or warm-up width does not fit");
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [P0_W-1:0] port0_output_latch_r;
  logic [P0_W-1:0] port0_drive_type_r;
  logic [P1_W-1:0] port1_output_latch_r;
  logic [P1_W-1:0] port1_direction_r;
  logic [P2_W-1:0] port2_output_latch_r;
  logic [P3_W-1:0] port3_output_latch_r;
  logic [P3_W-1:0] port3_direction_r;
  logic [DATA_W-1:0] rdata_r;
  logic hit_r;
  logic irq0_r;
  logic irq1_r;
  logic irq2_r;

  logic [P0_W-1:0] p0_lvl;
  logic [P1_W-1:0] p1_lvl;
  logic [P2_W-1:0] p2_lvl;
  logic [P3_W-1:0] p3_lvl;
  logic [P1_W-1:0] p1_prev;
  logic [P2_W-1:0] p2_prev;
  logic [P3_W-1:0] analog_mask;
  logic [P1_W-1:0] p1_dir_eff;
  logic [DATA_W-1:0] rdata_nxt;
  logic hit_nxt;
  logic wr_s2;
  logic rd_s1;
  logic [WARM_W-1:0] warm_r;
  logic hist_ok;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  fpio_sync_if #(.W(PIN_W)) pins_if ();

  assign pins_if.raw = {p3_in, p2_in, p1_in, p0_in};

  fpio_pin_sync #(
    .W(PIN_W),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .s(pins_if)
  );

  // Split the synchronised vector back into ports
  assign p0_lvl = pins_if.level[P0_LSB +: P0_W];
  assign p1_lvl = pins_if.level[P1_LSB +: P1_W];
  assign p2_lvl = pins_if.level[P2_LSB +: P2_W];
  assign p3_lvl = pins_if.level[P3_LSB +: P3_W];
  assign p1_prev = pins_if.level_prev[P1_LSB +: P1_W];
  assign p2_prev = pins_if.level_prev[P2_LSB +: P2_W];

  // ----------------------------------------------------------------
  // Cycle qualifiers
  // ----------------------------------------------------------------
  // Writes land in S2, reads sample in S1
  assign wr_s2 = sfr_wr && st_s2; // [RQ3]
  assign rd_s1 = sfr_rd && st_s1; // [RQ2]

  // ----------------------------------------------------------------
  // Port 0 latch and drive type
  // ----------------------------------------------------------------
  // Latch holds output data between writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      port0_output_latch_r <= RST_P0_LATCH; // [RQ4]
    end else if (wr_s2 && sfr_addr == OFS_P0_LATCH) begin
      port0_output_latch_r <= sfr_wdata; // [RQ1]
    end
  end

  // Drive type: zero open-drain, one push-pull
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      port0_drive_type_r <= RST_P0_DRIVE; // [RQ4]
    end else if (wr_s2 && sfr_addr == OFS_P0_DRIVE) begin
      port0_drive_type_r <= sfr_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Port 1 latch and direction
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      port1_output_latch_r <= RST_P1_LATCH; // [RQ7]
    end else if (wr_s2 && sfr_addr == OFS_P1_LATCH) begin
      port1_output_latch_r <= sfr_wdata[P1_W-1:0]; // [RQ1]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      port1_direction_r <= RST_P1_DIR; // [RQ7]
    end else if (wr_s2 && sfr_addr == OFS_P1_DIR) begin
      port1_direction_r <= sfr_wdata[P1_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Port 2 latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      port2_output_latch_r <= RST_P2_LATCH; // [RQ11]
    end else if (wr_s2 && sfr_addr == OFS_P2_LATCH) begin
      port2_output_latch_r <= sfr_wdata[P2_W-1:0]; // [RQ1]
    end
  end

  // ----------------------------------------------------------------
  // Port 3 latch and direction
  // ----------------------------------------------------------------
  // Latch still takes writes on analog pins; only the drive is held off
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      port3_output_latch_r <= RST_P3_LATCH; // [RQ15]
    end else if (wr_s2 && sfr_addr == OFS_P3_LATCH) begin
      port3_output_latch_r <= sfr_wdata; // [RQ1]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      port3_direction_r <= RST_P3_DIR; // [RQ15]
    end else if (wr_s2 && sfr_addr == OFS_P3_DIR) begin
      port3_direction_r <= sfr_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Open-drain pulls low only; push-pull drives both levels
  assign p0_out = port0_output_latch_r;
  assign p0_oe = port0_drive_type_r | ~port0_output_latch_r; // [RQ5]

  // Interrupt use of bit 0 forces it to input
  always_comb begin
    p1_dir_eff = port1_direction_r; // [RQ7]
    if (ext_irq_zero_pin_select) begin
      p1_dir_eff[P1_IRQ0_BIT] = 1'b0; // [RQ10] [RQ23]
    end
  end
  assign p1_out = port1_output_latch_r;
  assign p1_oe = p1_dir_eff;

  // Port 2 is open-drain; latch one releases the pin
  always_comb begin
    p2_oe = ~port2_output_latch_r; // [RQ11]
    if (stop_mode) begin
      p2_oe[P2_IRQ_BIT] = 1'b0; // [RQ13]
    end
  end
  assign p2_out = port2_output_latch_r;

  // Analog channel decode; one pin per selected channel
  always_comb begin
    analog_mask = '0;
    if (!analog_input_disable) begin
      analog_mask[analog_channel_select] = 1'b1; // [RQ16]
    end
  end
  assign p3_analog_sel = analog_mask;
  assign p3_out = port3_output_latch_r;
  assign p3_oe = port3_direction_r & ~analog_mask; // [RQ17] [RQ19]

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Input-mode pins give the pin level; output-mode and port 3 analog pins give the latch
  always_comb begin
    rdata_nxt = RD_IDLE;
    hit_nxt = 1'b1;
    case (sfr_addr)
      OFS_P0_LATCH: begin
        rdata_nxt = port0_output_latch_r; // [RQ6]
      end
      OFS_P0_PINS: begin
        rdata_nxt = p0_lvl; // [RQ6]
      end
      OFS_P0_DRIVE: begin
        rdata_nxt = port0_drive_type_r;
      end
      OFS_P1_LATCH: begin
        rdata_nxt[P1_W-1:0] = (p1_dir_eff & port1_output_latch_r) |
                              (~p1_dir_eff & p1_lvl); // [RQ20]
      end
      OFS_P1_DIR: begin
        rdata_nxt[P1_W-1:0] = port1_direction_r;
      end
      OFS_P2_LATCH: begin
        rdata_nxt[P2_W-1:0] = port2_output_latch_r; // [RQ12]
      end
      OFS_P2_PINS: begin
        rdata_nxt[P2_W-1:0] = p2_lvl; // [RQ12]
      end
      OFS_P3_LATCH: begin
        rdata_nxt = (analog_mask & port3_output_latch_r) |
                    (~analog_mask & port3_direction_r &
                     port3_output_latch_r) |
                    (~analog_mask & ~port3_direction_r &
                     p3_lvl); // [RQ18] [RQ20]
      end
      OFS_P3_DIR: begin
        rdata_nxt = port3_direction_r;
      end
      default: begin
        hit_nxt = 1'b0;
      end
    endcase
  end

  // Sample once in S1; holds until the next read, no pin latch exists
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= RD_IDLE;
      hit_r <= 1'b0;
    end else if (rd_s1) begin
      rdata_r <= rdata_nxt; // [RQ2] [RQ1]
      hit_r <= hit_nxt;
    end
  end

  assign sfr_rdata = rdata_r;
  assign sfr_hit = hit_r;

  // ----------------------------------------------------------------
  // Edge history warm-up
  // ----------------------------------------------------------------
  // History resets low; a pin high at release would fake an edge, so
  // edge flags wait until the chain and history hold real pin levels
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      warm_r <= '0;
    end else if (!hist_ok) begin
      warm_r <= warm_r + WARM_W'(1);
    end
  end
  assign hist_ok = (warm_r == WARM_W'(WARM_CYC));

  // ----------------------------------------------------------------
  // Shared interrupt edges
  // ----------------------------------------------------------------
  // Edges are seen on the pin itself, so own drive also triggers them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq0_r <= 1'b0;
      irq1_r <= 1'b0;
      irq2_r <= 1'b0;
    end else begin
      irq0_r <= hist_ok && ext_irq_zero_pin_select &&
                p1_prev[P1_IRQ0_BIT] && !p1_lvl[P1_IRQ0_BIT]; // [RQ10]
      irq1_r <= hist_ok &&
                (p1_prev[P1_IRQ1_BIT] ^ p1_lvl[P1_IRQ1_BIT]); // [RQ9]
      irq2_r <= hist_ok &&
                p2_prev[P2_IRQ_BIT] && !p2_lvl[P2_IRQ_BIT]; // [RQ14]
    end
  end

  assign irq0_fall = irq0_r;
  assign irq1_edge = irq1_r;
  assign irq2_fall = irq2_r;

endmodule : fpio_ports

// [verif/fpio_assertions.sv]
// Port checks of the four-port parallel I/O block.
// Assumes a bind to fpio_ports; one clock domain.
`timescale 1ns/10ps
module fpio_assertions (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic st_s1,
  input wire logic st_s2,
  input wire logic [fpio_pkg::ADDR_W-1:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic [fpio_pkg::DATA_W-1:0] sfr_wdata,
  input wire logic [fpio_pkg::DATA_W-1:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire logic ext_irq_zero_pin_select,
  input wire logic analog_input_disable,
  input wire logic [fpio_pkg::CHSEL_W-1:0] analog_channel_select,
  input wire logic stop_mode,
  input wire logic [fpio_pkg::P0_W-1:0] p0_out,
  input wire logic [fpio_pkg::P1_W-1:0] p1_oe,
  input wire logic [fpio_pkg::P2_W-1:0] p2_in,
  input wire logic [fpio_pkg::P2_W-1:0] p2_oe,
  input wire logic [fpio_pkg::P3_W-1:0] p3_oe,
  input wire logic [fpio_pkg::P3_W-1:0] p3_analog_sel,
  input wire logic irq2_fall
);
  import fpio_pkg::*;
  logic mapped;
  // ----
  // Helpers
  // ----
  // Addresses this block answers for
  assign mapped = sfr_addr <= OFS_P3_LATCH ||
    (sfr_addr >= OFS_P1_DIR && sfr_addr <= OFS_P2_PINS);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_read;
    sfr_rd && st_s1;
  endsequence
  sequence s_write;
    sfr_wr && st_s2;
  endsequence
  // High for three samples, then low: a clean falling edge
  sequence s_p2_drop;
    p2_in[0] [*3] ##1 !p2_in[0];
  endsequence
  property p_p0_wr;
    s_write ##0 sfr_addr == OFS_P0_LATCH |=> p0_out == $past(sfr_wdata);
  endproperty
  a_p0_wr: assert property (p_p0_wr)
    else $error("port 0 output missed its write");
  property p_p0_hold;
    !(sfr_wr && st_s2) |=> $stable(p0_out);
  endproperty
  a_p0_hold: assert property (p_p0_hold)
    else $error("port 0 output moved without a write");
  property p_hit;
    s_read |=> sfr_hit == $past(mapped);
  endproperty
  a_hit: assert property (p_hit)
    else $error("read hit flag wrong");
  property p_p2_upper;
    s_read ##0 (sfr_addr == OFS_P2_LATCH || sfr_addr == OFS_P2_PINS)
      |=> sfr_rdata[7:3] == 5'h00;
  endproperty
  a_p2_upper: assert property (p_p2_upper)
    else $error("port 2 upper read bits not zero");
  property p_stop;
    stop_mode |-> !p2_oe[P2_IRQ_BIT];
  endproperty
  a_stop: assert property (p_stop)
    else $error("port 2 bit 0 driven in stop mode");
  property p_an_on;
    !analog_input_disable |->
      p3_analog_sel == (8'h01 << analog_channel_select);
  endproperty
  a_an_on: assert property (p_an_on)
    else $error("analog pin select wrong");
  property p_an_drv;
    (p3_oe & p3_analog_sel) == 8'h00;
  endproperty
  a_an_drv: assert property (p_an_drv)
    else $error("analog pin driven");
  property p_irq0_sel;
    ext_irq_zero_pin_select |-> !p1_oe[P1_IRQ0_BIT];
  endproperty
  a_irq0_sel: assert property (p_irq0_sel)
    else $error("interrupt pin driven");
  property p_irq2;
    s_p2_drop |-> ##[1:5] irq2_fall;
  endproperty
  a_irq2: assert property (p_irq2)
    else $error("port 2 falling edge not flagged");
endmodule // fpio_assertions

bind fpio_ports fpio_assertions u_fpio_chk (
  .clk_sys, .rst_n, .st_s1, .st_s2, .sfr_addr, .sfr_rd, .sfr_wr,
  .sfr_wdata, .sfr_rdata, .sfr_hit, .ext_irq_zero_pin_select,
  .analog_input_disable, .analog_channel_select, .stop_mode, .p0_out,
  .p1_oe, .p2_in, .p2_oe, .p3_oe, .p3_analog_sel, .irq2_fall
);

// [verif/fpio_pin_model.sv]
// Pad model: each pin resolves block drive against the outside.
// Assumes the outside always holds a definite level on every pad.
`timescale 1ns/10ps
module fpio_pin_model (
  input wire logic [fpio_pkg::PIN_W-1:0] ext,
  input wire logic [fpio_pkg::PIN_W-1:0] drv,
  input wire logic [fpio_pkg::PIN_W-1:0] oe,
  output logic [fpio_pkg::PIN_W-1:0] pin
);
  import fpio_pkg::*;
  // Driven pads follow the block, released ones the outside level
  assign pin = (oe & drv) | (~oe & ext);
endmodule // fpio_pin_model

// [verif/testbench.sv]
// Self-checking bench for the four-port parallel I/O block.
// Assumes fpio_pin_model on the pads and the bound port checker.
`timescale 1ns/10ps
module testbench;
  import fpio_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic st_s1 = 1'b0;
  logic st_s2 = 1'b0;
  logic sfr_rd = 1'b0;
  logic sfr_wr = 1'b0;
  logic [ADDR_W-1:0] sfr_addr = 6'h00;
  logic [DATA_W-1:0] sfr_wdata = 8'h00;
  logic ext_irq_zero_pin_select = 1'b0;
  logic analog_input_disable = 1'b1;
  logic [CHSEL_W-1:0] analog_channel_select = 3'h0;
  logic stop_mode = 1'b0;
  logic [PIN_W-1:0] ext = 24'h000000;
  wire [PIN_W-1:0] drv;
  wire [PIN_W-1:0] oe;
  wire [PIN_W-1:0] pin;
  logic [DATA_W-1:0] sfr_rdata;
  logic [P3_W-1:0] p3_analog_sel;
  logic sfr_hit;
  logic irq0_fall;
  logic irq1_edge;
  logic irq2_fall;
  logic rd_take = 1'b0;
  logic [8:0] exp_q[$];
  logic [7:0] r;
  logic [7:0] d;
  logic [7:0] m;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_irq[3] = '{0, 0, 0};
  int k;

  fpio_ports dut (
    .clk_sys, .rst_n, .st_s1, .st_s2, .sfr_addr, .sfr_rd, .sfr_wr,
    .sfr_wdata, .sfr_rdata, .sfr_hit, .ext_irq_zero_pin_select,
    .analog_input_disable, .analog_channel_select, .stop_mode,
    .p0_in(pin[P0_LSB+:P0_W]), .p0_out(drv[P0_LSB+:P0_W]),
    .p0_oe(oe[P0_LSB+:P0_W]), .p1_in(pin[P1_LSB+:P1_W]),
    .p1_out(drv[P1_LSB+:P1_W]), .p1_oe(oe[P1_LSB+:P1_W]),
    .p2_in(pin[P2_LSB+:P2_W]), .p2_out(drv[P2_LSB+:P2_W]),
    .p2_oe(oe[P2_LSB+:P2_W]), .p3_in(pin[P3_LSB+:P3_W]),
    .p3_out(drv[P3_LSB+:P3_W]), .p3_oe(oe[P3_LSB+:P3_W]),
    .p3_analog_sel, .irq0_fall, .irq1_edge, .irq2_fall
  );
  fpio_pin_model u_pins (.ext(ext), .drv(drv), .oe(oe), .pin(pin));

  always #25 clk_sys = ~clk_sys;

  // ----
  // Checking and closing
  // ----
  task automatic chk(input string nm, input logic [PIN_W-1:0] seen,
                     input logic [PIN_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Bus cycles: request set after a falling edge, held over one sample
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    st_s2 = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
    st_s2 = 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [8:0] x);
    @(negedge clk_sys);
    exp_q.push_back(x);
    sfr_addr = a;
    sfr_rd = 1'b1;
    st_s1 = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    st_s1 = 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Read answers land on the sample edge; compare mid-cycle
  always @(posedge clk_sys) rd_take <= sfr_rd && st_s1;
  always @(negedge clk_sys) begin
    if (rd_take)
      chk("read", 24'({sfr_hit, sfr_rdata}), 24'(exp_q.pop_front()));
  end
  // Edge flag tally, and a ceiling on run length against hangs
  always @(posedge clk_sys) begin
    n_irq[0] <= n_irq[0] + int'(irq0_fall);
    n_irq[1] <= n_irq[1] + int'(irq1_edge);
    n_irq[2] <= n_irq[2] + int'(irq2_fall);
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    k = $urandom(32'h6e572124);
    idle(3);
    rst_n = 1'b1;
    idle(3);
    chk("oe", oe, 24'h000000);
    chk("p0out", 24'(drv[P0_LSB+:P0_W]), 24'hff);
    chk("asel", 24'(p3_analog_sel), 24'h00);
    rd(OFS_P0_DRIVE, 9'h100);
    rd(OFS_P1_DIR, 9'h100);
    rd(OFS_P3_DIR, 9'h100);
    rd(OFS_P2_LATCH, 9'h107);
    // Port 0: both drive kinds, latch against pin level
    repeat (4) begin
      r = 8'($urandom());
      ext[P0_LSB+:P0_W] = 8'($urandom());
      wr(OFS_P0_LATCH, r);
      chk("p0oe", 24'(oe[P0_LSB+:P0_W]), 24'(r ^ 8'hff));
      wr(OFS_P0_DRIVE, 8'hff);
      chk("p0oe", 24'(oe[P0_LSB+:P0_W]), 24'hff);
      idle(3);
      rd(OFS_P0_PINS, {1'b1, r});
      wr(OFS_P0_DRIVE, 8'h00);
      idle(3);
      rd(OFS_P0_PINS, {1'b1, r & ext[P0_LSB+:P0_W]});
    end
    // Foreign register outside this map; reserved cells are never touched
    wr(6'h10, 8'h5a);
    rd(OFS_P0_LATCH, {1'b1, r});
    rd(6'h10, 9'h000);
    // Port 1: latch ones before output mode, mixed read
    ext[P1_LSB+:P1_W] = 5'($urandom());
    wr(OFS_P1_LATCH, 8'h1f);
    d = 8'($urandom()) & 8'h1f;
    wr(OFS_P1_DIR, d);
    chk("p1oe", 24'(oe[P1_LSB+:P1_W]), 24'(d));
    idle(3);
    rd(OFS_P1_LATCH, {4'h8, d[4:0] | (ext[P1_LSB+:P1_W] & ~d[4:0])});
    ext_irq_zero_pin_select = 1'b1;
    wr(OFS_P1_DIR, 8'h1f);
    chk("p1oe", 24'(oe[P1_LSB+:P1_W]), 24'h1e);
    ext[P1_LSB] = 1'b1;
    idle(5);
    k = n_irq[0];
    ext[P1_LSB] = 1'b0;
    idle(6);
    chk("irq0", 24'(n_irq[0] - k), 24'd1);
    k = n_irq[1];
    wr(OFS_P1_LATCH, 8'h1d);
    idle(6);
    wr(OFS_P1_LATCH, 8'h1f);
    idle(6);
    chk("irq1", 24'(n_irq[1] - k), 24'd2);
    // Port 2: stop float, edge flag while driving low
    wr(OFS_P2_LATCH, 8'h00);
    chk("p2oe", 24'(oe[P2_LSB+:P2_W]), 24'h7);
    stop_mode = 1'b1;
    idle(1);
    chk("p2oe", 24'(oe[P2_LSB+:P2_W]), 24'h6);
    stop_mode = 1'b0;
    ext[P2_LSB+:P2_W] = 3'h7;
    wr(OFS_P2_LATCH, 8'h07);
    idle(5);
    k = n_irq[2];
    wr(OFS_P2_LATCH, 8'h06);
    idle(6);
    chk("irq2", 24'(n_irq[2] - k), 24'd1);
    rd(OFS_P2_PINS, 9'h106);
    rd(OFS_P2_LATCH, 9'h106);
    // Port 3: every analog channel against latch and direction
    analog_input_disable = 1'b0;
    for (int c = 0; c < 8; c++) begin
      r = 8'($urandom());
      d = 8'($urandom());
      m = 8'h01 << c;
      analog_channel_select = 3'(c);
      ext[P3_LSB+:P3_W] = d;
      wr(OFS_P3_LATCH, r);
      wr(OFS_P3_DIR, 8'hf0);
      chk("asel", 24'(p3_analog_sel), 24'(m));
      chk("p3oe", 24'(oe[P3_LSB+:P3_W]), 24'(8'hf0 & ~m));
      idle(3);
      rd(OFS_P3_LATCH, {1'b1, (r & (m | 8'hf0)) | (d & 8'h0f & ~m)});
    end
    analog_input_disable = 1'b1;
    idle(1);
    chk("asel", 24'(p3_analog_sel), 24'h00);
    idle(3);
    end_sim();
  end
endmodule // testbench
